// File: hdl/adc_gate_pkg.sv
// package: register offsets, field positions, reset values and carrier types
package adc_gate_pkg;
  localparam logic [7:0] OFF_GATE       = 8'h16; // channel gate register
  localparam logic [7:0] OFF_IIN_HIGH   = 8'h17; // input current, upper byte
  localparam logic [7:0] OFF_IIN_LOW    = 8'h18; // input current, lower byte
  localparam logic [7:0] OFF_ICHG_HIGH  = 8'h19; // charge current, upper byte
  localparam logic [7:0] OFF_ICHG_LOW   = 8'h1A; // charge current, lower byte
  localparam logic [7:0] GATE_RESET     = 8'h00; // every channel enabled
  localparam logic [7:0] RESULT_RESET   = 8'h00; // result bytes clear
  localparam logic [7:0] GATE_WRITABLE  = 8'hE7; // bits 4 and 3 not host-writable
  localparam logic [7:0] GATE_READABLE  = 8'hF7; // bit 3 reads zero
  localparam int         BIT_IIN        = 7;     // input current gate
  localparam int         BIT_ICHG       = 6;     // charge current gate
  localparam int         BIT_BUSV       = 5;     // bus voltage gate
  localparam int         BIT_VBAT       = 4;     // battery voltage gate
  localparam int         BIT_TS         = 2;     // thermistor gate
  localparam int         BIT_CELL       = 1;     // cell voltage gate
  localparam int         BIT_TDIE       = 0;     // die temperature gate
  localparam int         NUM_CHANNELS   = 7;     // channels steered by the gate

  // register write strobe from the serial interface
  typedef struct packed
  {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

  // one finished conversion from the converter core
  typedef struct packed
  {
    logic        iin_valid;
    logic [15:0] iin_value;
    logic        ichg_valid;
    logic [14:0] ichg_value;
  } conv_result_type;
endpackage

// File: hdl/adc_channel_gate_and_current_results.sv
// register slice: channel gate byte and the two current results
`timescale 1ns/1ps
//
// Contract
// [R1] gate bit one skips that channel's conversion
// [R2] gate bits 7,6,5,4,2,1,0; bit 3 zero
// [R3] zero reset; reg-reset restores; battery bit read-only
// [R4] input current 16-bit signed at 17h/18h
// [R5] input current one milliampere per bit
// [R6] positive into supply pin, negative out
// [R7] charge current 15-bit at 19h/1Ah, bit7 zero
// [R8] result bytes reset zero, survive watchdog
// [R9] no conversions while converter enable is low
// [R10] rate bit: continuous or one-shot pass
// [R11] both bytes of a result update together
module adc_channel_gate_and_current_results
  import adc_gate_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire reg_write_type           host_write,
  input  wire logic [7:0]              host_read_addr,
  input  wire logic                    host_read_strobe,
  output logic [7:0]                   host_read_data,
  output logic                         host_read_hit,
  input  wire logic                    register_reset,
  input  wire logic                    watchdog_expiry,
  input  wire logic                    converter_enable,
  input  wire logic                    converter_one_shot,
  input  wire conv_result_type         conv_result,
  output logic [NUM_CHANNELS-1:0]      channel_convert,
  output logic [7:0]                   gate_bits
);

  logic [7:0]  gate_r;          // channel gate register
  logic [7:0]  gate_nxt;        // next gate value
  logic [15:0] iin_r;           // input current result word
  logic [14:0] ichg_r;          // charge current result word
  logic [7:0]  read_data_r;     // registered read data
  logic        read_hit_r;      // registered address hit

  // permission vector skips reserved gate bit 3, so its top entries sit one below
  localparam int CH_IIN  = NUM_CHANNELS - 1; // permission index, input current
  localparam int CH_ICHG = NUM_CHANNELS - 2; // permission index, charge current

  // decode of host writes to the gate register
  wire         gate_write = host_write.wr && (host_write.addr == OFF_GATE);

  // host may change writable bits; battery bit and bit 3 keep stored value
  assign gate_nxt = (host_write.data & GATE_WRITABLE) | (gate_r & ~GATE_WRITABLE); // [R3]

  // watchdog is deliberately not wired here: these fields survive it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      gate_r <= GATE_RESET; // [R3]
    else if (register_reset)
      gate_r <= GATE_RESET; // [R3]
    else if (gate_write)
      gate_r <= gate_nxt;
  end

  // capture permission per result, read straight from the gate bits
  // a conversion that lands while gated or disabled is simply dropped
  wire         iin_allowed  = converter_enable && !gate_r[BIT_IIN];   // [R1] [R9]
  wire         ichg_allowed = converter_enable && !gate_r[BIT_ICHG];  // [R1] [R9]
  wire         iin_take     = conv_result.iin_valid && iin_allowed;   // input word arrives
  wire         ichg_take    = conv_result.ichg_valid && ichg_allowed; // charge word arrives

  // results hold the whole word so both bytes always come from one conversion
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      iin_r  <= {RESULT_RESET, RESULT_RESET}; // [R8]
      ichg_r <= '0; // [R8]
    end
    else if (register_reset)
    begin
      iin_r  <= {RESULT_RESET, RESULT_RESET}; // [R8]
      ichg_r <= '0; // [R8]
    end
    else
    begin
      // sign and scale pass through untouched: 1 mA per bit, into pin positive
      if (iin_take)
        iin_r <= conv_result.iin_value; // [R4] [R5] [R6] [R11]
      // charge word has no sign; bit 7 of its upper byte is padded on read
      if (ichg_take)
        ichg_r <= conv_result.ichg_value; // [R7] [R11]
    end
  end

  // per-channel permission: enable on and gate bit clear
  // one-shot vs continuous sequencing is the core's; the gate applies to both
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++)
    begin : g_chan
      localparam int GBIT = (ch < 3) ? ch : ch + 1; // skip reserved bit 3
      assign channel_convert[ch] = converter_enable && !gate_r[GBIT]; // [R1] [R9] [R10]
    end
  endgenerate

  assign gate_bits = gate_r & GATE_READABLE; // [R2]

  // read mux, combinational select of the addressed byte
  logic [7:0] read_mux;
  logic       read_match;
  always_comb
  begin
    read_mux   = 8'h00;
    read_match = 1'b1;
    case (host_read_addr)
      OFF_GATE:      read_mux = gate_r & GATE_READABLE; // [R2]
      OFF_IIN_HIGH:  read_mux = iin_r[15:8]; // [R4]
      OFF_IIN_LOW:   read_mux = iin_r[7:0]; // [R4]
      OFF_ICHG_HIGH: read_mux = {1'b0, ichg_r[14:8]}; // [R7]
      OFF_ICHG_LOW:  read_mux = ichg_r[7:0]; // [R7]
      default:       read_match = 1'b0; // other offsets are not ours
    endcase
  end

  // read data registered on the strobe
  // hit is registered beside the data so both stand in the same cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      read_data_r <= 8'h00;
      read_hit_r  <= 1'b0;
    end
    else
    begin
      read_hit_r <= host_read_strobe && read_match;
      if (host_read_strobe)
        read_data_r <= read_mux;
    end
  end

  assign host_read_data = read_data_r;
  assign host_read_hit  = read_hit_r;

  // checks on the gate register and the permission it grants
  // a gated input-current channel never gets permission
  property p_gate_skip;
    @(posedge clock) disable iff (!rstn)
      gate_r[BIT_IIN] |-> !channel_convert[CH_IIN];
  endproperty
  a_gate_skip: assert property (p_gate_skip) else $error("gated channel converts"); // [R1]

  // a gated input-current word is dropped and the old value stands
  property p_iin_dropped;
    @(posedge clock) disable iff (!rstn)
      (conv_result.iin_valid && gate_r[BIT_IIN] && !register_reset)
        |=> $stable(iin_r);
  endproperty
  a_iin_dropped: assert property (p_iin_dropped) else $error("gated iin stored"); // [R1]

  // same for the charge-current word
  property p_ichg_dropped;
    @(posedge clock) disable iff (!rstn)
      (conv_result.ichg_valid && gate_r[BIT_ICHG] && !register_reset)
        |=> $stable(ichg_r);
  endproperty
  a_ichg_dropped: assert property (p_ichg_dropped) else $error("gated ichg stored"); // [R1]

  // a clear charge-current gate bit grants permission while the converter runs
  property p_enabled;
    @(posedge clock) disable iff (!rstn)
      (converter_enable && !gate_r[BIT_ICHG]) |-> channel_convert[CH_ICHG];
  endproperty
  a_enabled: assert property (p_enabled) else $error("enabled channel idle"); // [R1] [R9]

  // reserved bit 3 always reads zero
  property p_reserved_zero;
    @(posedge clock) disable iff (!rstn)
      gate_bits[3] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("bit 3 not zero"); // [R2]

  // offsets outside the slice answer zero with no hit
  property p_no_hit;
    @(posedge clock) disable iff (!rstn)
      (host_read_strobe && !read_match) |=> !host_read_hit && (host_read_data == 8'h00);
  endproperty
  a_no_hit: assert property (p_no_hit) else $error("unmapped offset answered"); // [R2]

  // the battery-voltage gate bit cannot be written by the host
  property p_vbat_ro;
    @(posedge clock) disable iff (!rstn)
      (gate_write && !register_reset) |=> gate_r[BIT_VBAT] == $past(gate_r[BIT_VBAT]);
  endproperty
  a_vbat_ro: assert property (p_vbat_ro) else $error("battery gate written"); // [R3]

  // a host write stores only the writable bits
  property p_gate_write;
    @(posedge clock) disable iff (!rstn)
      (gate_write && !register_reset)
        |=> gate_bits == ($past(host_write.data) & GATE_WRITABLE);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gate write mismatch"); // [R3]

  // the register-reset command clears the gate and both results
  property p_regrst;
    @(posedge clock) disable iff (!rstn)
      register_reset |=> (gate_r == GATE_RESET) && (iin_r == 16'h0000) && (ichg_r == '0);
  endproperty
  a_regrst: assert property (p_regrst) else $error("reg reset missed"); // [R3] [R8]

  // a watchdog expiry leaves the gate as it was
  property p_watchdog_keeps;
    @(posedge clock) disable iff (!rstn)
      (watchdog_expiry && !register_reset && !gate_write) |=> $stable(gate_r);
  endproperty
  a_watchdog_keeps: assert property (p_watchdog_keeps) else $error("watchdog changed gate"); // [R3]

  // a watchdog expiry leaves both results as they were
  property p_wdog_results;
    @(posedge clock) disable iff (!rstn)
      (watchdog_expiry && !register_reset && !iin_take && !ichg_take)
        |=> $stable(iin_r) && $stable(ichg_r);
  endproperty
  a_wdog_results: assert property (p_wdog_results) else $error("watchdog hit results"); // [R8]

  // checks on the read path
  // the input-current upper byte reads back the stored word
  property p_iin_read;
    @(posedge clock) disable iff (!rstn)
      (host_read_strobe && host_read_addr == OFF_IIN_HIGH)
        |=> host_read_data == $past(iin_r[15:8]);
  endproperty
  a_iin_read: assert property (p_iin_read) else $error("iin high read wrong"); // [R4]

  // the input-current lower byte reads back the stored word
  property p_iin_low;
    @(posedge clock) disable iff (!rstn)
      (host_read_strobe && host_read_addr == OFF_IIN_LOW)
        |=> host_read_data == $past(iin_r[7:0]);
  endproperty
  a_iin_low: assert property (p_iin_low) else $error("iin low read wrong"); // [R4]

  // unused top bit of the charge-current upper byte reads zero
  property p_ichg_top;
    @(posedge clock) disable iff (!rstn)
      (host_read_strobe && host_read_addr == OFF_ICHG_HIGH) |=> !host_read_data[7];
  endproperty
  a_ichg_top: assert property (p_ichg_top) else $error("ichg bit 7 set"); // [R7]

  // the charge-current lower byte reads back the stored word
  property p_ichg_low;
    @(posedge clock) disable iff (!rstn)
      (host_read_strobe && host_read_addr == OFF_ICHG_LOW)
        |=> host_read_data == $past(ichg_r[7:0]);
  endproperty
  a_ichg_low: assert property (p_ichg_low) else $error("ichg low read wrong"); // [R7]

  // host writes never reach the result words
  property p_result_ro;
    @(posedge clock) disable iff (!rstn)
      (host_write.wr && !iin_take && !ichg_take && !register_reset)
        |=> $stable(iin_r) && $stable(ichg_r);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result written by host"); // [R4] [R7]

  // checks on conversion permission and capture
  // no permission at all while the converter is off
  property p_disabled;
    @(posedge clock) disable iff (!rstn)
      !converter_enable |-> channel_convert == '0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("conversion while disabled"); // [R9]

  // in one-shot mode the gate still decides who converts
  property p_one_shot;
    @(posedge clock) disable iff (!rstn)
      (converter_one_shot && converter_enable && !gate_r[BIT_IIN]) |-> channel_convert[CH_IIN];
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot lost permission"); // [R10]

  // a taken input-current word is stored whole in the next cycle
  property p_pair;
    @(posedge clock) disable iff (!rstn)
      (iin_take && !register_reset) |=> iin_r == $past(conv_result.iin_value);
  endproperty
  a_pair: assert property (p_pair) else $error("result word not captured whole"); // [R11] [R5]

  // a taken charge-current word is stored whole in the next cycle
  property p_ichg_pair;
    @(posedge clock) disable iff (!rstn)
      (ichg_take && !register_reset) |=> ichg_r == $past(conv_result.ichg_value);
  endproperty
  a_ichg_pair: assert property (p_ichg_pair) else $error("ichg word split"); // [R11] [R7]

  // the sign bit of the input current survives capture
  property p_sign;
    @(posedge clock) disable iff (!rstn)
      (iin_take && !register_reset && conv_result.iin_value[15]) |=> iin_r[15];
  endproperty
  a_sign: assert property (p_sign) else $error("input current sign lost"); // [R6]

  // main scenarios reached
  c_write_gate: cover property (@(posedge clock) disable iff (!rstn) gate_write);
  c_iin_update: cover property (@(posedge clock) disable iff (!rstn) iin_take);
  c_regrst:     cover property (@(posedge clock) disable iff (!rstn) register_reset);
  c_one_shot:   cover property (@(posedge clock) disable iff (!rstn) converter_one_shot);
  c_refused:    cover property (@(posedge clock) disable iff (!rstn) host_write.wr && !gate_write);

endmodule

// File: sim/host_model.sv
// host controller model: register writes and reads
`timescale 1ns/1ps
module host_model
  import adc_gate_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] host_read_data,
  input  wire logic       host_read_hit,
  output reg_write_type   host_write,
  output logic [7:0]      host_read_addr,
  output logic            host_read_strobe
);
  // idle bus at time zero
  initial
  begin
    host_write = '0;
    host_read_addr = 8'h00;
    host_read_strobe = 1'b0;
  end
  // one-cycle write pulse off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock) host_write = '{1'b1, a, v};
    @(negedge clock) host_write = '0;
  endtask
  // answer is registered, so sample one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic h);
    @(negedge clock) host_read_addr = a;
    host_read_strobe = 1'b1;
    @(negedge clock) host_read_strobe = 1'b0;
    v = host_read_data;
    h = host_read_hit;
  endtask
endmodule

// File: sim/adc_channel_gate_and_current_results_test.sv
// testbench: gate and current result registers against a reference model
`timescale 1ns/1ps
module adc_channel_gate_and_current_results_test
  import adc_gate_pkg::*;
;
  logic            clock, rstn, register_reset, watchdog_expiry, h;
  logic            converter_enable, converter_one_shot, host_read_strobe, host_read_hit;
  conv_result_type conv_result;
  reg_write_type   host_write;
  logic [7:0]      host_read_addr, host_read_data, gate_bits, d;
  logic [6:0]      channel_convert;
  int              failures = 0, n_checks = 0, cycles = 0, gate = 0, iin = 0, ichg = 0;

  adc_channel_gate_and_current_results dut (.clock, .rstn, .host_write, .host_read_addr,
    .host_read_strobe, .host_read_data, .host_read_hit, .register_reset, .watchdog_expiry,
    .converter_enable, .converter_one_shot, .conv_result, .channel_convert, .gate_bits);
  host_model host (.clock, .host_read_data, .host_read_hit, .host_write, .host_read_addr,
    .host_read_strobe);

  // 25 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // hang guard, well beyond the run length
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      results();
    end
  end
  // byte comparison for read data and the gate output
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // single-bit comparison for the read hit
  task automatic check_flag(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // comparison of the per-channel permission vector
  task automatic check_convert(input logic [6:0] exp, input logic [6:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR convert expected %h seen %h", exp, got);
    end
  endtask
  // read one offset and compare data and hit
  task automatic read_reg(input logic [7:0] a, input int exp);
    host.rd(a, d, h);
    check_byte("read data", 8'(exp), d);
    check_flag("read hit", a >= OFF_GATE && a <= OFF_ICHG_LOW, h);
  endtask
  // sweep every register, one unmapped offset and the side outputs
  task automatic read_all();
    read_reg(OFF_GATE, gate);
    read_reg(OFF_IIN_HIGH, iin >> 8);
    read_reg(OFF_IIN_LOW, iin);
    read_reg(OFF_ICHG_HIGH, ichg >> 8);
    read_reg(OFF_ICHG_LOW, ichg);
    read_reg(8'h1B, 0);
    check_byte("gate bits", 8'(gate), gate_bits);
    check_convert(converter_enable ? ~{gate[7:4], gate[2:0]} : 7'h00,
      channel_convert);
  endtask
  // host write; model keeps only writable bits
  task automatic set_gate(input logic [7:0] v);
    host.wr(OFF_GATE, v);
    gate = v & GATE_WRITABLE;
  endtask
  // one conversion of both currents; gated or disabled results are dropped
  task automatic convert(input logic [15:0] vi, input logic [14:0] vc);
    @(negedge clock) conv_result = '{1'b1, vi, 1'b1, vc};
    if (converter_enable && !gate[7]) iin = vi;
    if (converter_enable && !gate[6]) ichg = vc;
    @(negedge clock) conv_result = '0;
    read_all();
  endtask
  // close the run
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {rstn, register_reset, watchdog_expiry, converter_one_shot} = 4'h0;
    converter_enable = 1'b1;
    conv_result = '0;
    void'($urandom(32'h0D3444A4));
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    read_all();
    set_gate(8'hFF);
    convert(16'($urandom), 15'($urandom));
    set_gate(8'h00);
    convert(16'h8001, 15'h7FFF);
    repeat (3) convert(16'($urandom), 15'($urandom));
    // result offsets refuse host writes
    host.wr(OFF_IIN_HIGH, 8'($urandom));
    host.wr(OFF_ICHG_LOW, 8'($urandom));
    read_all();
    converter_enable = 1'b0;
    convert(16'($urandom), 15'($urandom));
    converter_enable = 1'b1;
    converter_one_shot = 1'b1;
    set_gate(8'h40);
    convert(16'($urandom), 15'($urandom));
    @(negedge clock) watchdog_expiry = 1'b1;
    @(negedge clock) watchdog_expiry = 1'b0;
    read_all();
    // register reset in the same cycle as a gate write: reset wins
    fork
      host.wr(OFF_GATE, 8'hFF);
      begin
        @(negedge clock) register_reset = 1'b1;
        @(negedge clock) register_reset = 1'b0;
      end
    join
    {gate, iin, ichg} = '0;
    read_all();
    // second asynchronous reset in mid-run, from a loaded state
    set_gate(8'hBF);
    convert(16'($urandom), 15'($urandom));
    @(negedge clock) rstn = 1'b0;
    @(negedge clock) rstn = 1'b1;
    {gate, iin, ichg} = '0;
    read_all();
    results();
  end
endmodule
